// [lcd_instr_map.svh]
// Offsets, field positions, reset values and timing counts of the instruction decoder.
// Assumes a 125 MHz clock and byte addressing on a 32-bit APB bus.
`ifndef LCD_INSTR_MAP_SVH
`define LCD_INSTR_MAP_SVH

// Clock period in ns
`define CLK_PERIOD_NS 8
// Execution times in ns
`define EXEC_SHORT_NS 18500
`define EXEC_LONG_NS 760000
`define BLINK_NS 185000000
// Cycle counts, rounded down (completion bounds)
`define EXEC_SHORT_CYC (`EXEC_SHORT_NS / `CLK_PERIOD_NS)
`define EXEC_LONG_CYC (`EXEC_LONG_NS / `CLK_PERIOD_NS)
`define BLINK_CYC (`BLINK_NS / `CLK_PERIOD_NS)

// APB byte offsets
`define REG_INSTR 8'h00
`define REG_DATA 8'h04
`define REG_STATUS 8'h08

// Status register fields
`define ST_PANEL 0
`define ST_CURSOR 1
`define ST_BLINK 2
`define ST_PHASE 3
`define ST_INCR 4
`define ST_SHIFTEN 5
`define ST_WIDE 6
`define ST_TWOLINE 7
`define ST_TALL 8
`define ST_GLYPH 9
`define ST_OFFSET_LSB 16

// Busy flag position in the instruction read
`define BUSY_BIT 7

// Reset and fill values
`define SPACE_CODE 8'h20
`define AC_HOME 7'h00
`define LINE1_LAST 7'h27
`define LINE2_FIRST 7'h40
`define LINE2_LAST 7'h67
`define ONE_LINE_LAST 7'h4f
`define LINE_LEN 7'd40
`define RAM_LEN 7'd80
`endif

// [lcd_instr_pkg.sv]
// Types shared by the instruction decoder.
// Assumes lcd_instr_map.svh supplies all numbers.
package lcd_instr_pkg;

	typedef enum logic {
		PH_IDLE = 1'b0,
		PH_BUSY = 1'b1
	} phase_t;

	typedef struct packed {
		logic panelOn;
		logic cursorOn;
		logic blinkOn;
		logic blinkPhase;
		logic [6:0] shiftOffset;
		logic [6:0] cursorAddr;
		logic twoLine;
		logic tallFont;
		logic busWidthSelect;
	} display_view_t;

	typedef struct packed {
		phase_t phase;
		logic [16:0] busyCnt;
		logic [24:0] blinkCnt;
		logic glyphSel;
		logic incr;
		logic shiftEn;
		display_view_t view;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [79:0][7:0] displayRam;
		logic [63:0][7:0] glyphRam;
	} state_t;

endpackage

// [char_lcd_instruction_decoder.sv]
// Instruction decoder and execution control of a character display controller.
// Assumes an APB master on the host side and a panel driver reading the view outputs.
// Contract
// - Data read returns byte at address counter
// - Data write stores byte at address counter
// - Clear fills spaces, homes, forces increment
// - Return home zeroes counter, undoes shift
// - Entry mode direction steers counter step
// - Glyph RAM steps like display RAM
// - Shift-enabled display writes shift whole display
// - No shift on reads, glyph, disabled
// - Display enable blanks panel, keeps RAM
// - Cursor enable leaves direction untouched
// - Blink alternates cursor every 185 ms
// - Cursor shift steps counter without access
// - Display shift moves whole display
// - Display shift keeps address counter
// - Two-line cursor wraps to second line
// - All lines shift together
// - Function set latches width, lines, font
// - Glyph address load selects glyph RAM
// - Display address load selects display RAM
// - Status read gives busy and counter
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "lcd_instr_map.svh"

module char_lcd_instruction_decoder
	import lcd_instr_pkg::*;
#(
	parameter int LONG_CYCLES = `EXEC_LONG_CYC,
	parameter int BLINK_CYCLES = `BLINK_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic busyFlag,
	output display_view_t view
);

	localparam logic [16:0] SHORT_LAST = 17'(`EXEC_SHORT_CYC - 1);
	localparam logic [16:0] LONG_LAST = 17'(LONG_CYCLES - 1);
	localparam logic [24:0] BLINK_LAST = 25'(BLINK_CYCLES - 1);

	state_t st;
	state_t next_st;

	function automatic state_t initState();
		state_t s;
		s = '0;
		s.phase = PH_IDLE;
		s.incr = 1'b1;
		s.view.busWidthSelect = 1'b1;
		for (int i = 0; i < 80; i++) begin
			s.displayRam[i] = `SPACE_CODE;
		end
		return s;
	endfunction

	// Next address counter value after one step
	function automatic logic [6:0] stepAc(logic [6:0] ac, logic up, logic glyph, logic two);
		logic [6:0] r;
		r = ac;
		if (glyph) begin
			r = {1'b0, (up ? ac[5:0] + 6'd1 : ac[5:0] - 6'd1)};
		end else if (two) begin
			if (up) begin
				r = (ac == `LINE1_LAST) ? `LINE2_FIRST : (ac == `LINE2_LAST) ? `AC_HOME : ac + 7'd1;
			end else begin
				r = (ac == `LINE2_FIRST) ? `LINE1_LAST : (ac == `AC_HOME) ? `LINE2_LAST : ac - 7'd1;
			end
		end else begin
			if (up) begin
				r = (ac == `ONE_LINE_LAST) ? `AC_HOME : ac + 7'd1;
			end else begin
				r = (ac == `AC_HOME) ? `ONE_LINE_LAST : ac - 7'd1;
			end
		end
		return r;
	endfunction

	// New display offset after a whole-display shift
	function automatic logic [6:0] shiftOff(logic [6:0] off, logic left, logic two);
		logic [6:0] last;
		last = two ? `LINE_LEN - 7'd1 : `RAM_LEN - 7'd1;
		if (left) begin
			return (off >= last) ? 7'd0 : off + 7'd1;
		end
		return (off == 7'd0 || off > last) ? last : off - 7'd1;
	endfunction

	// Display RAM slot of an address, 80 when unmapped
	function automatic logic [6:0] ramIdx(logic [6:0] ac, logic two);
		logic [6:0] r;
		r = ac;
		if (two) begin
			r = (ac[5:0] < 6'd40) ? (ac[6] ? 7'd40 + {1'b0, ac[5:0]} : {1'b0, ac[5:0]}) : `RAM_LEN;
		end else if (ac > `ONE_LINE_LAST) begin
			r = `RAM_LEN;
		end
		return r;
	endfunction

	logic setup;
	logic access;
	logic [7:0] wbyte;
	logic [6:0] idx;
	logic [7:0] rdByte;

	always_comb begin
		setup = psel && !penable;
		access = psel && penable && st.pready;
		wbyte = pwdata[7:0];
		idx = ramIdx(st.view.cursorAddr, st.view.twoLine);
		if (st.glyphSel) begin
			rdByte = st.glyphRam[st.view.cursorAddr[5:0]];
		end else if (idx < `RAM_LEN) begin
			rdByte = st.displayRam[idx];
		end else begin
			rdByte = `SPACE_CODE;
		end

		next_st = st;
		next_st.pready = 1'b0;

		// Busy countdown
		if (st.phase == PH_BUSY) begin
			if (st.busyCnt == 17'd0) begin
				next_st.phase = PH_IDLE;
			end else begin
				next_st.busyCnt = st.busyCnt - 17'd1;
			end
		end

		if (st.view.blinkOn) begin
			if (st.blinkCnt >= BLINK_LAST) begin
				next_st.blinkCnt = 25'd0;
				next_st.view.blinkPhase = !st.view.blinkPhase;
			end else begin
				next_st.blinkCnt = st.blinkCnt + 25'd1;
			end
		end else begin
			next_st.blinkCnt = 25'd0;
			next_st.view.blinkPhase = 1'b0;
		end

		// Setup phase prepares the answer
		if (setup) begin
			next_st.pready = 1'b1;
			next_st.pslverr = 1'b0;
			next_st.prdata = 32'h0;
			case (paddr)
				`REG_INSTR: begin
					next_st.prdata[`BUSY_BIT] = (st.phase == PH_BUSY);
					next_st.prdata[6:0] = st.view.cursorAddr;
				end
				`REG_DATA: begin
					next_st.prdata[7:0] = rdByte;
				end
				`REG_STATUS: begin
					next_st.prdata[`ST_PANEL] = st.view.panelOn;
					next_st.prdata[`ST_CURSOR] = st.view.cursorOn;
					next_st.prdata[`ST_BLINK] = st.view.blinkOn;
					next_st.prdata[`ST_PHASE] = st.view.blinkPhase;
					next_st.prdata[`ST_INCR] = st.incr;
					next_st.prdata[`ST_SHIFTEN] = st.shiftEn;
					next_st.prdata[`ST_WIDE] = st.view.busWidthSelect;
					next_st.prdata[`ST_TWOLINE] = st.view.twoLine;
					next_st.prdata[`ST_TALL] = st.view.tallFont;
					next_st.prdata[`ST_GLYPH] = st.glyphSel;
					next_st.prdata[`ST_OFFSET_LSB +: 7] = st.view.shiftOffset;
				end
				default: begin
					next_st.pslverr = 1'b1;
				end
			endcase
		end

		if (access && st.phase == PH_IDLE && (paddr == `REG_INSTR || paddr == `REG_DATA)) begin
			if (paddr == `REG_DATA) begin
				next_st.phase = PH_BUSY;
				next_st.busyCnt = SHORT_LAST;
				if (pwrite) begin
					if (st.glyphSel) begin
						next_st.glyphRam[st.view.cursorAddr[5:0]] = wbyte;
					end else if (idx < `RAM_LEN) begin
						next_st.displayRam[idx] = wbyte;
					end
					if (st.shiftEn && !st.glyphSel) begin
						next_st.view.shiftOffset = shiftOff(st.view.shiftOffset, st.incr, st.view.twoLine);
					end
				end
				next_st.view.cursorAddr = stepAc(st.view.cursorAddr, st.incr, st.glyphSel, st.view.twoLine);
			end else if (pwrite) begin
				next_st.phase = PH_BUSY;
				next_st.busyCnt = SHORT_LAST;
				casez (wbyte)
					8'b1???????: begin
						next_st.view.cursorAddr = wbyte[6:0];
						next_st.glyphSel = 1'b0;
					end
					8'b01??????: begin
						next_st.view.cursorAddr = {1'b0, wbyte[5:0]};
						next_st.glyphSel = 1'b1;
					end
					8'b001?????: begin
						next_st.view.busWidthSelect = wbyte[4];
						next_st.view.twoLine = wbyte[3];
						next_st.view.tallFont = wbyte[2];
					end
					8'b0001????: begin
						if (wbyte[3]) begin
							next_st.view.shiftOffset = shiftOff(st.view.shiftOffset, !wbyte[2], st.view.twoLine);
						end else begin
							next_st.view.cursorAddr = stepAc(st.view.cursorAddr, wbyte[2], st.glyphSel,
								st.view.twoLine);
						end
					end
					8'b00001???: begin
						next_st.view.panelOn = wbyte[2];
						next_st.view.cursorOn = wbyte[1];
						next_st.view.blinkOn = wbyte[0];
					end
					8'b000001??: begin
						next_st.incr = wbyte[1];
						next_st.shiftEn = wbyte[0];
					end
					8'b0000001?: begin
						next_st.view.cursorAddr = `AC_HOME;
						next_st.view.shiftOffset = 7'd0;
						next_st.glyphSel = 1'b0;
						next_st.busyCnt = LONG_LAST;
					end
					8'b00000001: begin
						for (int i = 0; i < 80; i++) begin
							next_st.displayRam[i] = `SPACE_CODE;
						end
						next_st.view.cursorAddr = `AC_HOME;
						next_st.view.shiftOffset = 7'd0;
						next_st.glyphSel = 1'b0;
						next_st.incr = 1'b1;
						next_st.busyCnt = LONG_LAST;
					end
					default: begin
						next_st.phase = PH_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= initState();
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign busyFlag = st.phase == PH_BUSY;
	assign view = st.view;

endmodule

// [char_lcd_instruction_decoder_props.sv]
// Assertions on the decoder ports.
// Assumes zero-wait APB answers and the package view struct.
`timescale 1ns/1ns
`include "lcd_instr_map.svh"
module char_lcd_instruction_decoder_props
	import lcd_instr_pkg::*;
#(
	parameter int LONG_CYCLES = 95000,
	parameter int BLINK_CYCLES = 23125000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic busyFlag,
	input wire display_view_t view
);
	localparam int MAX_RUN = (LONG_CYCLES > 2312) ? LONG_CYCLES : 2312;
	int busyRun;
	logic take;
	logic [7:0] ins;
	assign take = psel && penable && pready && pwrite && paddr == `REG_INSTR && !busyFlag;
	assign ins = pwdata[7:0];
	always_ff @(posedge clk) begin
		busyRun <= (!rst_n || !busyFlag) ? 0 : busyRun + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_CLEAR: assert property (take && ins == 8'h01 |=> view.cursorAddr == 7'h00 && busyFlag)
		else $error("clear did not home the counter");
	AST_HOME: assert property (take && ins[7:1] == 7'h01 |=> view.cursorAddr == 7'h00 && view.shiftOffset == 7'h00)
		else $error("home left counter or shift");
	AST_ONOFF: assert property (take && ins[7:3] == 5'h01 |=> view.panelOn == $past(ins[2]) && view.cursorOn == $past(ins[1]))
		else $error("display control not latched");
	AST_FSET: assert property (take && ins[7:5] == 3'h1 |=> view.twoLine == $past(ins[3]) && view.tallFont == $past(ins[2]))
		else $error("function settings not latched");
	AST_GLYPH_ADDR: assert property (take && ins[7:6] == 2'h1 |=> view.cursorAddr == {1'b0, $past(ins[5:0])})
		else $error("glyph address not loaded");
	AST_DISP_ADDR: assert property (take && ins[7] |=> view.cursorAddr == $past(ins[6:0]))
		else $error("display address not loaded");
	AST_SHIFT_KEEP: assert property (take && ins[7:3] == 5'h03 |=> $stable(view.cursorAddr))
		else $error("display shift moved the counter");
	AST_STATUS: assert property (psel && penable && pready && !pwrite && paddr == `REG_INSTR |-> prdata[6:0] == view.cursorAddr && prdata[31:8] == 24'h0)
		else $error("status read wrong counter");
	AST_DATA_BUSY: assert property (psel && penable && pready && pwrite && paddr == `REG_DATA && !busyFlag |=> busyFlag)
		else $error("data write did not set busy");
	AST_BUSY_END: assert property (busyRun <= MAX_RUN)
		else $error("busy lasted too long");
	COV_CLEAR: cover property (take && ins == 8'h01);
	COV_SHIFT: cover property (take && ins[7:3] == 5'h03);
	COV_GLYPH: cover property (take && ins[7:6] == 2'h1);
endmodule
bind char_lcd_instruction_decoder char_lcd_instruction_decoder_props #(.LONG_CYCLES(LONG_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) props (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .busyFlag(busyFlag), .view(view));

// [host_apb_model.sv]
// Host processor model: APB master issuing decoder accesses.
// Assumes it is called right after a rising clock edge.
`timescale 1ns/1ns
`include "lcd_instr_map.svh"
module host_apb_model (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		@(posedge clk);
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		do begin
			xfer(1'b0, `REG_INSTR, 32'h0, r, e);
		end while (r[7] !== 1'b0);
		xfer(w, a, d, r, e);
	endtask
endmodule

// [test_char_lcd_instruction_decoder.sv]
// Self-checking bench of the instruction decoder.
// Assumes the host model waits for busy low before every access.
`timescale 1ns/1ns
`include "lcd_instr_map.svh"
module test_char_lcd_instruction_decoder;
	import lcd_instr_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, busyFlag, e, p;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	display_view_t view;
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	always #4 clk = ~clk;
	host_apb_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	char_lcd_instruction_decoder #(.LONG_CYCLES(50), .BLINK_CYCLES(20)) dut (.clk(clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .busyFlag(busyFlag), .view(view));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wi(input logic [7:0] d);
		host.acc(1'b1, `REG_INSTR, {24'h0, d}, r, e);
	endtask
	task automatic wd(input logic [7:0] d);
		host.acc(1'b1, `REG_DATA, {24'h0, d}, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		host.acc(1'b0, a, 32'h0, r, e);
		check(r, exp);
	endtask
	task automatic report_and_stop();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`REG_STATUS, 32'h50);
		rd(`REG_INSTR, 32'h0);
		wi(8'h01);
		wi(8'h38);
		rd(`REG_STATUS, 32'hd0);
		$display("test setup done");
		wi(8'ha7);
		wd(8'h41);
		rd(`REG_INSTR, 32'h40);
		wi(8'ha7);
		rd(`REG_DATA, 32'h41);
		rd(`REG_INSTR, 32'h40);
		wi(8'h04);
		wi(8'h80);
		wd(8'h42);
		rd(`REG_INSTR, 32'h67);
		wi(8'h14);
		rd(`REG_INSTR, 32'h0);
		wi(8'h10);
		rd(`REG_INSTR, 32'h67);
		wi(8'h18);
		rd(`REG_STATUS, 32'h100c0);
		rd(`REG_INSTR, 32'h67);
		$display("test moves done");
		wi(8'h07);
		wi(8'h80);
		wd(8'h43);
		rd(`REG_DATA, 32'h20);
		rd(`REG_STATUS, 32'h200f0);
		wi(8'h03);
		rd(`REG_INSTR, 32'h0);
		rd(`REG_STATUS, 32'hf0);
		rd(`REG_DATA, 32'h43);
		wi(8'h7f);
		wd(8'h1f);
		rd(`REG_INSTR, 32'h0);
		rd(`REG_STATUS, 32'h2f0);
		wi(8'h7f);
		rd(`REG_DATA, 32'h1f);
		$display("test shifts done");
		wi(8'h0f);
		#1;
		check({29'h0, view.panelOn, view.cursorOn, view.blinkOn}, 32'h7);
		p = view.blinkPhase;
		repeat (20) @(posedge clk);
		#1;
		check({31'h0, view.blinkPhase}, {31'h0, ~p});
		@(posedge clk);
		wi(8'h08);
		#1;
		check({31'h0, view.panelOn}, 32'h0);
		@(posedge clk);
		wi(8'h80);
		rd(`REG_DATA, 32'h43);
		rd(`REG_STATUS, 32'hf0);
		wi(8'h04);
		wi(8'h01);
		rd(`REG_DATA, 32'h20);
		rd(`REG_STATUS, 32'hd0);
		host.acc(1'b0, 8'h0c, 32'h0, r, e);
		check({31'h0, e}, 32'h1);
		$display("test control done");
		report_and_stop();
	end
endmodule
